// ---- hdl/dwu_dual_watchdog.sv ----
// Dual watchdog unit: CPU-clock watchdog, slow-oscillator watchdog, APB
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1 - 30-bit main counter raises interrupt or system reset at time-out
// R2 - Main counter advances only on CPU clock ticks; halts when CPU stops
// R3 - Expiry flag set on every main time-out; software clears it
// R4 - Main interrupt requested only with its separate enable bit set
// R5 - Main reset cause flag set after a main watchdog reset
// R6 - Main reset cause flag cleared by every other hardware reset
// R7 - Main system reset only when reset enable set; enabled, longest out of reset
// R8 - Writing one to restart strobe zeroes main counter; strobe holds nothing
// R9 - Restart only after timed-access unlock; locked restart write is ignored
// R10 - Time-out select codes give 2^17, 2^20, 2^23, 2^26 counts
// R11 - Timer prescale bits pick CPU clock by 4 when set, by 12 when clear
// R12 - Second 16-bit watchdog runs from the free-running slow oscillator
// R13 - Slow reset cause flag set after slow reset; cleared by writing zero
// R14 - Slow watchdog longest time-out reaches about 18 hours
// R15 - Slow counter matched with 16-bit time-out; value bytes read live count
// R16 - Slow prescale codes divide by 2^8, or 2^12 to 2^15
// R17 - Writing one to slow clear bit zeroes counter; bit self-clears
// R18 - Slow reset needs reset enable; slow interrupt needs interrupt enable
// R19 - Slow interrupt flag set on slow event; cleared by writing zero
module dwu_dual_watchdog
    import dwu_pkg::*;
#(
    parameter logic [29:0] MAIN_PERIOD_C0 = MAIN_PERIOD_0,
    parameter logic [29:0] MAIN_PERIOD_C1 = MAIN_PERIOD_1,
    parameter logic [29:0] MAIN_PERIOD_C2 = MAIN_PERIOD_2,
    parameter logic [29:0] MAIN_PERIOD_C3 = MAIN_PERIOD_3
)
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic PWR_ON_RST,
    input wire logic CPU_CLK_TICK,
    input wire logic SLOW_OSC_CLOCK,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [17:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    output logic SLOW_WAKE,
    output logic SYS_RESET_REQ,
    output logic [2:0] TIMER_TICK
);

    // ==========================================================
    // Declarations
    logic any_rst;
    logic rst_d_r;
    logic [15:0] idx;
    logic addr_ok;
    logic wr_ok;
    logic [7:0] rd_data;
    logic [7:0] clk_ctrl_r;
    logic expiry_flag_r;
    logic main_cause_r;
    logic main_rst_en_r;
    logic main_mark_r;
    logic main_irq_en_r;
    logic [29:0] main_cnt_r;
    logic [29:0] main_period;
    logic main_expire;
    logic restart_req;
    dwu_unlock_t unl_r;
    logic [3:0] unl_win_r;
    logic [1:0] irq_status_r;
    logic [1:0] irq_mask_r;
    logic [1:0] irq_event;
    logic osc_s1_r;
    logic osc_s2_r;
    logic osc_s3_r;
    logic osc_edge;
    logic [14:0] pre_cnt_r;
    logic [14:0] pre_mask;
    logic slow_tick;
    logic [15:0] slow_cnt_r;
    logic [15:0] slow_timeout_r;
    logic slow_event;
    logic slow_clear;
    logic slow_rst_en_r;
    logic slow_cause_r;
    logic slow_irq_en_r;
    logic [2:0] slow_code_r;
    logic slow_irq_flag_r;
    logic slow_mark_r;
    logic reset_req_r;

    assign any_rst = RST | PWR_ON_RST;

    // ==========================================================
    // APB slave, zero wait states
    assign idx = PADDR[17:2];
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~addr_ok;
    assign wr_ok = PSEL & PENABLE & PWRITE & addr_ok;

    always_comb
    begin
        rd_data = 8'h00;
        addr_ok = (PADDR[1:0] == 2'h0);
        unique case (idx)
            IDX_CLK_CTRL: rd_data = clk_ctrl_r;
            IDX_MAIN_CTRL:
            begin
                rd_data[POS_EXPIRY] = expiry_flag_r;
                rd_data[POS_MAIN_CAUSE] = main_cause_r;
                rd_data[POS_MAIN_RST_EN] = main_rst_en_r;
            end
            IDX_EXT_IRQ_EN: rd_data[POS_MAIN_IRQ_EN] = main_irq_en_r;
            IDX_UNLOCK: rd_data[0] = (unl_r == UNL_OPEN);
            IDX_IRQ_STATUS: rd_data[1:0] = irq_status_r;
            IDX_IRQ_MASK: rd_data[1:0] = irq_mask_r;
            IDX_SLOW_CFG:
            begin
                rd_data[POS_SLOW_RST_EN] = slow_rst_en_r;
                rd_data[POS_SLOW_CAUSE] = slow_cause_r;
                rd_data[POS_SLOW_IRQ_EN] = slow_irq_en_r;
                rd_data[POS_SLOW_CODE +: 3] = slow_code_r;
                rd_data[POS_SLOW_IRQ_FLAG] = slow_irq_flag_r;
            end
            // Live count, not the programmed time-out
            IDX_SLOW_VAL_LO: rd_data = slow_cnt_r[7:0];   // see R15
            IDX_SLOW_VAL_HI: rd_data = slow_cnt_r[15:8];  // see R15
            default: addr_ok = 1'b0;
        endcase
    end

    // Captured in the setup cycle so read data comes from a flop
    always_ff @(posedge MCLK)
    begin
        if (any_rst)
            PRDATA <= 32'h0000_0000;
        else if (PSEL && !PENABLE && !PWRITE)
            PRDATA <= {24'h00_0000, rd_data};
    end

    // ==========================================================
    // Timed-access unlock: key pair opens a short window
    always_ff @(posedge MCLK)
    begin
        if (any_rst)
        begin
            unl_r <= UNL_IDLE;
            unl_win_r <= 4'h0;
        end
        else
        begin
            if (unl_win_r != 4'h0)
                unl_win_r <= unl_win_r - 4'h1;
            unique case (unl_r)
                UNL_IDLE:
                    if (wr_ok && idx == IDX_UNLOCK
                        && PWDATA[7:0] == UNLOCK_KEY1)
                        unl_r <= UNL_KEY1;
                UNL_KEY1:
                    if (wr_ok)
                    begin
                        if (idx == IDX_UNLOCK && PWDATA[7:0] == UNLOCK_KEY2)
                        begin
                            unl_r <= UNL_OPEN;
                            unl_win_r <= UNLOCK_WIN_CYC;
                        end
                        else
                            unl_r <= UNL_IDLE;
                    end
                UNL_OPEN:
                    // One protected write per unlock
                    if (restart_req || unl_win_r == 4'h0)
                        unl_r <= UNL_IDLE;
            endcase
        end
    end

    // Locked restart writes complete on the bus but do not restart the main counter
    assign restart_req = wr_ok && idx == IDX_MAIN_CTRL
        && PWDATA[POS_RESTART] && unl_r == UNL_OPEN;  // see R8, R9

    // ==========================================================
    // Clock and time-out control, timer prescalers
    always_ff @(posedge MCLK)
    begin
        if (any_rst)
            clk_ctrl_r <= CLK_CTRL_RST;  // see R7
        else if (wr_ok && idx == IDX_CLK_CTRL)
            clk_ctrl_r <= {PWDATA[7:2], 2'b00};
    end

    // Top select bit has no documented codes above 011; it is ignored
    always_comb
    begin
        unique case ({clk_ctrl_r[POS_WD1], clk_ctrl_r[POS_WD0]})
            2'b00: main_period = MAIN_PERIOD_C0;  // see R10
            2'b01: main_period = MAIN_PERIOD_C1;  // see R10
            2'b10: main_period = MAIN_PERIOD_C2;  // see R10
            2'b11: main_period = MAIN_PERIOD_C3;  // see R10
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gen_tmr
            logic [3:0] div_cnt_r;
            logic [3:0] div;
            logic tick_r;
            assign div = clk_ctrl_r[POS_T0_PRESC + g] ? TMR_DIV_FAST
                : TMR_DIV_SLOW;  // see R11
            always_ff @(posedge MCLK)
            begin
                if (any_rst)
                begin
                    div_cnt_r <= 4'h0;
                    tick_r <= 1'b0;
                end
                else
                begin
                    tick_r <= 1'b0;
                    if (CPU_CLK_TICK)
                    begin
                        if (div_cnt_r >= div - 4'h1)
                        begin
                            div_cnt_r <= 4'h0;
                            tick_r <= 1'b1;  // see R11
                        end
                        else
                            div_cnt_r <= div_cnt_r + 4'h1;
                    end
                end
            end
        end
    endgenerate
    // One driver for the whole output vector
    assign TIMER_TICK = {gen_tmr[2].tick_r, gen_tmr[1].tick_r,
        gen_tmr[0].tick_r};

    // ==========================================================
    // Main watchdog counter
    assign main_expire = CPU_CLK_TICK && !restart_req
        && main_cnt_r == main_period - 30'h1;  // see R1

    always_ff @(posedge MCLK)
    begin
        if (any_rst)
            main_cnt_r <= 30'h0;
        else if (restart_req)
            main_cnt_r <= 30'h0;  // see R8
        else if (CPU_CLK_TICK)  // see R2
            main_cnt_r <= main_expire ? 30'h0 : main_cnt_r + 30'h1;
    end

    always_ff @(posedge MCLK)
    begin
        if (any_rst)
        begin
            expiry_flag_r <= MAIN_CTRL_RST[POS_EXPIRY];
            main_rst_en_r <= MAIN_CTRL_RST[POS_MAIN_RST_EN];  // see R7
            main_irq_en_r <= 1'b0;
        end
        else
        begin
            if (main_expire)
                expiry_flag_r <= 1'b1;  // see R3
            else if (wr_ok && idx == IDX_MAIN_CTRL)
                expiry_flag_r <= PWDATA[POS_EXPIRY];
            if (wr_ok && idx == IDX_MAIN_CTRL)
                main_rst_en_r <= PWDATA[POS_MAIN_RST_EN];
            if (wr_ok && idx == IDX_EXT_IRQ_EN)
                main_irq_en_r <= PWDATA[POS_MAIN_IRQ_EN];
        end
    end

    // Marks survive the system reset they cause, then cleared on release
    always_ff @(posedge MCLK)
    begin
        rst_d_r <= RST;
        if (PWR_ON_RST)
        begin
            main_mark_r <= 1'b0;
            slow_mark_r <= 1'b0;
        end
        else if (RST)
        begin
            main_mark_r <= main_mark_r;
            slow_mark_r <= slow_mark_r;
        end
        else if (rst_d_r)
        begin
            main_mark_r <= 1'b0;
            slow_mark_r <= 1'b0;
        end
        else
        begin
            if (main_expire && main_rst_en_r)
                main_mark_r <= 1'b1;
            if (slow_event && slow_rst_en_r)
                slow_mark_r <= 1'b1;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (PWR_ON_RST)
        begin
            main_cause_r <= 1'b0;  // see R6
            slow_cause_r <= 1'b0;
        end
        else if (RST)
        begin
            main_cause_r <= main_mark_r;  // see R5, R6
            slow_cause_r <= slow_mark_r;  // see R13
        end
        else
        begin
            if (wr_ok && idx == IDX_MAIN_CTRL)
                main_cause_r <= PWDATA[POS_MAIN_CAUSE];
            if (wr_ok && idx == IDX_SLOW_CFG && !PWDATA[POS_SLOW_CAUSE])
                slow_cause_r <= 1'b0;  // see R13
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (any_rst)
            reset_req_r <= 1'b0;
        else if ((main_expire && main_rst_en_r)
            || (slow_event && slow_rst_en_r))  // see R7, R18
            reset_req_r <= 1'b1;
    end
    assign SYS_RESET_REQ = reset_req_r;

    // ==========================================================
    // Slow watchdog: oscillator edges, prescaler, counter
    always_ff @(posedge MCLK)
    begin
        osc_s1_r <= SLOW_OSC_CLOCK;
        osc_s2_r <= osc_s1_r;
        osc_s3_r <= osc_s2_r;
    end
    assign osc_edge = osc_s2_r & ~osc_s3_r;  // see R12

    // Prescale 2^15 times 2^16 counts of 32 kHz is roughly 18 hours
    assign pre_mask = (slow_code_r[2] ? 15'h7FFF >> (4'hF
        - ({1'b0, slow_code_r} + SLOW_SHIFT_OFS))
        : 15'h7FFF >> (4'hF - SLOW_SHIFT_MIN));  // see R16, R14
    assign slow_tick = osc_edge && ((pre_cnt_r & pre_mask) == pre_mask);
    assign slow_clear = wr_ok && idx == IDX_SLOW_CFG
        && PWDATA[POS_SLOW_CLEAR];
    assign slow_event = slow_tick && !slow_clear
        && slow_cnt_r == slow_timeout_r;  // see R15

    always_ff @(posedge MCLK)
    begin
        if (any_rst || slow_clear)  // see R17
        begin
            pre_cnt_r <= 15'h0;
            slow_cnt_r <= 16'h0;
        end
        else
        begin
            if (osc_edge)
                pre_cnt_r <= pre_cnt_r + 15'h1;
            if (slow_tick)
                slow_cnt_r <= slow_event ? 16'h0 : slow_cnt_r + 16'h1;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (any_rst)
        begin
            slow_timeout_r <= {SLOW_VAL_HI_RST, SLOW_VAL_LO_RST};
            slow_rst_en_r <= SLOW_CFG_RST[POS_SLOW_RST_EN];
            slow_irq_en_r <= SLOW_CFG_RST[POS_SLOW_IRQ_EN];
            slow_code_r <= SLOW_CFG_RST[POS_SLOW_CODE +: 3];
            slow_irq_flag_r <= SLOW_CFG_RST[POS_SLOW_IRQ_FLAG];
        end
        else
        begin
            if (wr_ok && idx == IDX_SLOW_VAL_LO)
                slow_timeout_r[7:0] <= PWDATA[7:0];
            if (wr_ok && idx == IDX_SLOW_VAL_HI)
                slow_timeout_r[15:8] <= PWDATA[7:0];
            if (wr_ok && idx == IDX_SLOW_CFG)
            begin
                slow_rst_en_r <= PWDATA[POS_SLOW_RST_EN];
                slow_irq_en_r <= PWDATA[POS_SLOW_IRQ_EN];
                slow_code_r <= PWDATA[POS_SLOW_CODE +: 3];
            end
            if (slow_event)
                slow_irq_flag_r <= 1'b1;  // see R19
            else if (wr_ok && idx == IDX_SLOW_CFG
                && !PWDATA[POS_SLOW_IRQ_FLAG])
                slow_irq_flag_r <= 1'b0;  // see R19
        end
    end
    assign SLOW_WAKE = slow_irq_flag_r & slow_irq_en_r;  // see R12, R18

    // ==========================================================
    // Interrupt status, write one to clear; set wins
    assign irq_event[EV_MAIN] = main_expire & main_irq_en_r;  // see R4
    assign irq_event[EV_SLOW] = slow_event & slow_irq_en_r;  // see R18

    always_ff @(posedge MCLK)
    begin
        if (any_rst)
        begin
            irq_status_r <= 2'h0;
            irq_mask_r <= IRQ_MASK_RST;
        end
        else
        begin
            if (wr_ok && idx == IDX_IRQ_STATUS)
                irq_status_r <= (irq_status_r & ~PWDATA[1:0]) | irq_event;
            else
                irq_status_r <= irq_status_r | irq_event;
            if (wr_ok && idx == IDX_IRQ_MASK)
                irq_mask_r <= PWDATA[1:0];
        end
    end
    assign IRQ = |(irq_status_r & irq_mask_r);

    // ==========================================================
    // Checks
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST || PWR_ON_RST);

    chk_main_wrap: assert property (main_expire |=> main_cnt_r == 30'h0) // see R1
        else $error("main counter did not restart after expiry");
    chk_main_halt: assert property ( // see R2
        !CPU_CLK_TICK && !restart_req |=> $stable(main_cnt_r))
        else $error("main counter moved without cpu tick");
    chk_expiry_flag: assert property (main_expire |=> expiry_flag_r) // see R3
        else $error("expiry flag not set on time-out");
    chk_main_irq_gate: assert property ( // see R4
        $rose(irq_status_r[EV_MAIN]) |-> $past(main_irq_en_r))
        else $error("main interrupt without enable");
    chk_cause_latch: assert property ( // see R5
        $fell(RST) && !PWR_ON_RST |-> main_cause_r == main_mark_r)
        else $error("main reset cause not latched");
    chk_reset_enable: assert property ( // see R7
        $rose(SYS_RESET_REQ) |-> $past(main_expire && main_rst_en_r)
        || $past(slow_event && slow_rst_en_r))
        else $error("system reset without enabled expiry");
    chk_restart_zero: assert property (restart_req |=> main_cnt_r == 30'h0) // see R8
        else $error("restart did not zero main counter");
    chk_locked_restart: assert property ( // see R9
        wr_ok && idx == IDX_MAIN_CTRL && unl_r != UNL_OPEN
        && !CPU_CLK_TICK |=> $stable(main_cnt_r))
        else $error("locked restart changed main counter");
    chk_main_period: assert property ( // see R10
        main_expire |-> main_cnt_r == (clk_ctrl_r[POS_WD1]
        ? (clk_ctrl_r[POS_WD0] ? MAIN_PERIOD_C3 : MAIN_PERIOD_C2)
        : (clk_ctrl_r[POS_WD0] ? MAIN_PERIOD_C1 : MAIN_PERIOD_C0)) - 30'h1)
        else $error("main expiry at wrong count");
    chk_slow_match: assert property ( // see R15
        slow_event |-> slow_cnt_r == slow_timeout_r ##1 slow_cnt_r == 16'h0)
        else $error("slow event off its time-out value");
    chk_slow_clear: assert property ( // see R17
        slow_clear |=> slow_cnt_r == 16'h0 && pre_cnt_r == 15'h0)
        else $error("slow clear did not zero counter");
    chk_slow_flag: assert property (slow_event |=> slow_irq_flag_r) // see R19
        else $error("slow interrupt flag not set");

endmodule : dwu_dual_watchdog

`default_nettype wire

// ---- hdl/dwu_pkg.sv ----
// Shared constants and types of the dual watchdog unit
package dwu_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [15:0] IDX_CLK_CTRL = 16'h008E;
    localparam logic [15:0] IDX_MAIN_CTRL = 16'h00D8;
    localparam logic [15:0] IDX_EXT_IRQ_EN = 16'h00E8;
    localparam logic [15:0] IDX_UNLOCK = 16'h00C7;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'h00F0;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h00F1;
    localparam logic [15:0] IDX_SLOW_CFG = 16'hA0D8;
    localparam logic [15:0] IDX_SLOW_VAL_LO = 16'hA0D9;
    localparam logic [15:0] IDX_SLOW_VAL_HI = 16'hA0DA;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] CLK_CTRL_RST = 8'hC4;
    localparam logic [7:0] MAIN_CTRL_RST = 8'h02;
    localparam logic [7:0] SLOW_CFG_RST = 8'hA7;
    localparam logic [7:0] SLOW_VAL_LO_RST = 8'hFF;
    localparam logic [7:0] SLOW_VAL_HI_RST = 8'h0F;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;

    // ==========================================================
    // Field positions
    localparam int POS_WD1 = 7;
    localparam int POS_WD0 = 6;
    localparam int POS_T0_PRESC = 3;
    localparam int POS_WD2 = 2;
    localparam int POS_EXPIRY = 3;
    localparam int POS_MAIN_CAUSE = 2;
    localparam int POS_MAIN_RST_EN = 1;
    localparam int POS_RESTART = 0;
    localparam int POS_MAIN_IRQ_EN = 4;
    localparam int POS_SLOW_CLEAR = 7;
    localparam int POS_SLOW_RST_EN = 6;
    localparam int POS_SLOW_CAUSE = 5;
    localparam int POS_SLOW_IRQ_EN = 4;
    localparam int POS_SLOW_CODE = 1;
    localparam int POS_SLOW_IRQ_FLAG = 0;
    localparam int EV_MAIN = 0;
    localparam int EV_SLOW = 1;

    // ==========================================================
    // Counts
    localparam logic [29:0] MAIN_PERIOD_0 = 30'h0002_0000;
    localparam logic [29:0] MAIN_PERIOD_1 = 30'h0010_0000;
    localparam logic [29:0] MAIN_PERIOD_2 = 30'h0080_0000;
    localparam logic [29:0] MAIN_PERIOD_3 = 30'h0400_0000;
    localparam logic [3:0] TMR_DIV_FAST = 4'h4;
    localparam logic [3:0] TMR_DIV_SLOW = 4'hC;
    localparam logic [3:0] SLOW_SHIFT_MIN = 4'h8;
    localparam logic [3:0] SLOW_SHIFT_OFS = 4'h8;
    localparam logic [7:0] UNLOCK_KEY1 = 8'hAA;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h55;
    localparam logic [3:0] UNLOCK_WIN_CYC = 4'h8;

    typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_OPEN} dwu_unlock_t;

endpackage : dwu_pkg

// ---- verification/dwu_dual_watchdog_tb.sv ----
// Self-checking testbench of the dual watchdog unit
`timescale 1ns/1ps
`default_nettype none
module dwu_dual_watchdog_tb
    import dwu_pkg::*;
;
    // ==========
    // Stimulus and observation
    typedef struct packed
    {
        logic w;
        logic [15:0] i;
        logic [7:0] d;
        logic [7:0] e;
        logic x;
    } dwu_row_t;
    logic mclk = 1'b0, rst = 1'b1, por = 1'b1, tick = 1'b0, osc = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, wake, sysrst, er;
    logic [2:0] ttick, mon;
    int mismatches = 0, n_compared = 0, n, t0, cyc = 0;
    int cnt [3];
    dwu_row_t rows [14] = '{
        '{1'b0, IDX_CLK_CTRL, 8'h00, CLK_CTRL_RST, 1'b0},
        '{1'b0, IDX_MAIN_CTRL, 8'h00, MAIN_CTRL_RST, 1'b0},
        '{1'b0, IDX_EXT_IRQ_EN, 8'h00, 8'h00, 1'b0},
        '{1'b0, IDX_IRQ_MASK, 8'h00, {6'h0, IRQ_MASK_RST}, 1'b0},
        '{1'b0, IDX_IRQ_STATUS, 8'h00, 8'h00, 1'b0},
        '{1'b0, IDX_SLOW_CFG, 8'h00, SLOW_CFG_RST & 8'h5F, 1'b0},
        '{1'b1, IDX_CLK_CTRL, 8'hFF, 8'h00, 1'b0},
        '{1'b0, IDX_CLK_CTRL, 8'h00, 8'hFC, 1'b0},
        '{1'b1, IDX_EXT_IRQ_EN, 8'h10, 8'h00, 1'b0},
        '{1'b0, IDX_EXT_IRQ_EN, 8'h00, 8'h10, 1'b0},
        '{1'b1, IDX_IRQ_MASK, 8'h03, 8'h00, 1'b0},
        '{1'b0, IDX_IRQ_MASK, 8'h00, 8'h03, 1'b0},
        '{1'b0, 16'h0001, 8'h00, 8'h00, 1'b1},
        '{1'b1, 16'h0002, 8'h55, 8'h00, 1'b1}};
    assign mon = {wake, sysrst, irq};
    always #12.5 mclk = ~mclk;
    // Oscillator sped up so one prescaler tick costs 2048 cycles
    always #100 osc = ~osc;
    always @(posedge mclk) cyc <= cyc + 1;
    dwu_dual_watchdog #(.MAIN_PERIOD_C0(30'h10), .MAIN_PERIOD_C1(30'h20),
        .MAIN_PERIOD_C2(30'h40), .MAIN_PERIOD_C3(30'h80)) i_dwu_dual_watchdog
    (
        .MCLK(mclk), .RST(rst), .PWR_ON_RST(por), .CPU_CLK_TICK(tick),
        .SLOW_OSC_CLOCK(osc), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .IRQ(irq), .SLOW_WAKE(wake),
        .SYS_RESET_REQ(sysrst), .TIMER_TICK(ttick)
    );
    // ==========
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rng(input string nm, input int lo, input int hi);
        n_compared++;
        if (n < lo || n > hi)
        begin
            mismatches++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, n);
        end
    endtask : rng
    task automatic apb(input logic w, input logic [15:0] i,
        input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge mclk);
        pen <= 1'b1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask : wr
    task automatic rdc(input string nm, input logic [15:0] i,
        input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk(nm, {24'h0, e}, rd);
    endtask : rdc
    task automatic wait_hi(input int s, input int lim);
        n = 0;
        while (mon[s] !== 1'b1 && n < lim)
        begin
            @(posedge mclk);
            n++;
        end
    endtask : wait_hi
    task automatic do_reset(input logic p);
        @(posedge mclk);
        rst <= 1'b1;
        por <= p;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        por <= 1'b0;
        @(posedge mclk);
    endtask : do_reset
    task automatic restart();
        wr(IDX_UNLOCK, UNLOCK_KEY1);
        wr(IDX_UNLOCK, UNLOCK_KEY2);
        wr(IDX_MAIN_CTRL, 8'h01);
    endtask : restart
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    // ==========
    // Tests
    initial
    begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        por <= 1'b0;
        foreach (rows[k])
        begin
            apb(rows[k].w, rows[k].i, rows[k].d);
            chk("pslverr", {31'h0, rows[k].x}, er);
            if (!rows[k].w)
                chk("rdata", {24'h0, rows[k].e}, rd);
        end
        $display("test registers done");
        // Longest period, split by a stopped CPU clock
        tick <= 1'b1;
        repeat (100) @(posedge mclk);
        tick <= 1'b0;
        repeat (200) @(posedge mclk);
        chk("halted", 32'h0, sysrst);
        tick <= 1'b1;
        wait_hi(1, 60);
        rng("expiry", 27, 31);
        tick <= 1'b0;
        chk("irq main", 32'h1, irq);
        rdc("main ctrl", IDX_MAIN_CTRL, 8'h0A);
        do_reset(1'b0);
        chk("reset req", 32'h0, sysrst);
        rdc("main cause", IDX_MAIN_CTRL, 8'h06);
        do_reset(1'b1);
        rdc("main cause", IDX_MAIN_CTRL, 8'h02);
        $display("test main reset done");
        wr(IDX_CLK_CTRL, 8'h68);
        wr(IDX_MAIN_CTRL, 8'h00);
        tick <= 1'b1;
        repeat (24) @(posedge mclk);
        cnt = '{0, 0, 0};
        repeat (48)
        begin
            @(posedge mclk);
            for (int b = 0; b < 3; b++)
                if (ttick[b] === 1'b1)
                    cnt[b]++;
        end
        tick <= 1'b0;
        chk("t0 ticks", 48 / TMR_DIV_FAST, cnt[0]);
        chk("t1 ticks", 48 / TMR_DIV_SLOW, cnt[1]);
        chk("t2 ticks", 48 / TMR_DIV_FAST, cnt[2]);
        rdc("expiry flag", IDX_MAIN_CTRL, 8'h08);
        rdc("status", IDX_IRQ_STATUS, 8'h00);
        wr(IDX_MAIN_CTRL, 8'h00);
        rdc("flag clear", IDX_MAIN_CTRL, 8'h00);
        $display("test timers done");
        wr(IDX_EXT_IRQ_EN, 8'h10);
        wr(IDX_IRQ_MASK, 8'h01);
        restart();
        tick <= 1'b1;
        t0 = cyc;
        repeat (10) @(posedge mclk);
        wr(IDX_MAIN_CTRL, 8'h01);
        wait_hi(0, 40);
        n = cyc - t0;
        rng("locked restart", 31, 36);
        wr(IDX_IRQ_STATUS, 8'h01);
        @(negedge mclk);
        chk("irq cleared", 32'h0, irq);
        restart();
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        chk("restarted", 32'h0, irq);
        wait_hi(0, 24);
        rng("after restart", 9, 16);
        wr(IDX_IRQ_MASK, 8'h00);
        @(negedge mclk);
        chk("irq masked", 32'h0, irq);
        tick <= 1'b0;
        $display("test restart done");
        wr(IDX_SLOW_VAL_LO, 8'h01);
        wr(IDX_SLOW_VAL_HI, 8'h00);
        wr(IDX_IRQ_MASK, 8'h02);
        wr(IDX_SLOW_CFG, 8'h90);
        wait_hi(2, 5000);
        rng("slow period", 2000, 4200);
        chk("irq slow", 32'h1, irq);
        rdc("slow cfg", IDX_SLOW_CFG, 8'h11);
        wr(IDX_SLOW_CFG, 8'h10);
        @(negedge mclk);
        chk("wake clear", 32'h0, wake);
        wr(IDX_SLOW_CFG, 8'h40);
        wait_hi(1, 5000);
        rng("slow reset", 1, 4200);
        chk("no wake", 32'h0, wake);
        do_reset(1'b0);
        rdc("slow cause", IDX_SLOW_CFG, SLOW_CFG_RST & 8'h7F);
        wr(IDX_SLOW_CFG, 8'h07);
        rdc("slow cause clr", IDX_SLOW_CFG, 8'h07);
        rdc("main cause", IDX_MAIN_CTRL, 8'h02);
        $display("test slow watchdog done");
        // One 2^8 tick lands near 2048 cycles, the second near 4096
        wr(IDX_SLOW_CFG, 8'h80);
        repeat (3000) @(posedge mclk);
        rdc("live count lo", IDX_SLOW_VAL_LO, 8'h01);
        rdc("live count hi", IDX_SLOW_VAL_HI, 8'h00);
        wr(IDX_SLOW_CFG, 8'h8E);
        repeat (3000) @(posedge mclk);
        rdc("long prescale", IDX_SLOW_VAL_LO, 8'h00);
        $display("test slow prescale done");
        give_verdict();
    end
    // Hang guard, well past the longest expected run
    initial
    begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        $display("ERROR watchdog expected finish seen hang");
        give_verdict();
    end
endmodule : dwu_dual_watchdog_tb
`default_nettype wire
